// *** core/cxd_exception_dispatch.sv ***
// Purpose: Exception recognition, priority and vectoring for the core.
// Assumes: Pipeline shows at most one instruction fault per cycle,
//          and only while busy_o is low; inputs synchronous.
// Notes:   APB answers with one wait state; unmapped reads give error.
module cxd_exception_dispatch
   import cxd_pkg::*;
#(
   parameter int                  NERR    = 8,
   parameter logic [cxd_pkg::VW-1:0] VEC_MGMT = 20'h00f00
) (
   input  wire logic                 ref_clk_i,
   input  wire logic                 rst_i,
   input  wire logic                 clk_en_i,
   input  wire logic                 psel_i,
   input  wire logic                 penable_i,
   input  wire logic                 pwrite_i,
   input  wire logic [cxd_pkg::AW-1:0] paddr_i,
   input  wire logic [cxd_pkg::DW-1:0] pwdata_i,
   output logic      [cxd_pkg::DW-1:0] prdata_o,
   output logic                      pready_o,
   output logic                      pslverr_o,
   input  wire logic                 hard_core_reset_i,
   input  wire logic                 soft_reset_pin_i,
   input  wire logic                 irq_ctrl_sreset_i,
   input  wire logic                 nmi_i,
   input  wire logic [NERR-1:0]      int_err_i,
   input  wire logic                 irq_ctrl_int_i,
   input  wire logic                 sys_mgmt_irq_i,
   input  wire logic                 down_counter_msb_i,
   input  wire logic                 instr_done_i,
   input  wire logic                 exec_empty_i,
   input  wire logic                 handler_done_i,
   input  wire logic                 dacc_valid_i,
   input  wire logic                 dacc_no_xlate_i,
   input  wire logic                 dacc_prot_i,
   input  wire logic                 dacc_ext_ctl_i,
   input  wire logic                 dacc_write_thru_i,
   input  wire logic                 dacc_direct_store_i,
   input  wire logic                 dacc_store_i,
   input  wire logic                 fetch_valid_i,
   input  wire logic                 fetch_no_xlate_i,
   input  wire logic                 fetch_direct_store_i,
   input  wire logic                 fetch_prot_i,
   input  wire logic                 al_valid_i,
   input  wire logic                 al_fp_i,
   input  wire logic                 al_word_op_i,
   input  wire logic                 al_misalign_i,
   input  wire logic                 al_direct_store_i,
   input  wire logic                 al_seg_cross_i,
   input  wire logic                 al_ds_change_i,
   input  wire logic                 al_zero_blk_i,
   input  wire logic                 al_wt_or_ci_i,
   input  wire logic                 al_multi_str_i,
   input  wire logic                 al_ext_ctl_i,
   output logic                      take_o,
   output logic      [cxd_pkg::VW-1:0] vector_o,
   output logic                      sync_o,
   output logic                      precise_o,
   output logic                      busy_o,
   output logic                      machine_check_out_o
);
   import cxd_pkg::*;

   // ***************************************************
   // State
   // ***************************************************
   logic [DW-1:0]   cfg_ff;
   logic [DC_W-1:0] dcause_ff;
   logic [SR_W-1:0] saved_ff;
   cxd_state_t      state_ff;
   logic            dcnt_prev_ff;
   logic            dcnt_pend_ff;
   logic            take_ff;
   logic [VW-1:0]   vector_ff;
   logic            sync_ff;
   logic            precise_ff;
   logic            mout_ff;
   logic [DW-1:0]   prdata_ff;
   logic            pready_ff;
   logic            pslverr_ff;

   logic            rst_req;
   logic            mchk_req;
   logic            dsi_req;
   logic            fetch_req;
   logic            al_req;
   logic            async_ok;
   logic            ext_req;
   logic            dcnt_req;
   logic            mgmt_req;
   logic            nxt_take;
   logic [VW-1:0]   nxt_vector;
   logic            nxt_sync;
   logic            nxt_precise;
   logic            idle;
   logic            apb_wr;
   logic            apb_setup;
   logic            hit;
   logic [DW-1:0]   rd_mux;

   assign idle = (state_ff == ST_IDLE);

   // ***************************************************
   // Request conditions
   // ***************************************************
   // System reset sources
   assign rst_req  = hard_core_reset_i | soft_reset_pin_i | irq_ctrl_sreset_i;
   // All three enables must agree; the pin counts as an always-enabled error
   assign mchk_req = (nmi_i | (|(int_err_i & cfg_ff[CFG_ERR_LSB +: NERR])))
                     & cfg_ff[CFG_PIN_EN] & cfg_ff[CFG_MOUT_EN]
                     & cfg_ff[CFG_MCHK_EN];
   // Data access fault from any recorded cause
   assign dsi_req  = dacc_valid_i & (dacc_no_xlate_i | dacc_prot_i
                     | (dacc_ext_ctl_i & dacc_write_thru_i) | dacc_direct_store_i
                     | (dacc_ext_ctl_i & ~cfg_ff[CFG_XACC_EN]));
   // Fetch fault
   assign fetch_req = fetch_valid_i & (fetch_no_xlate_i | fetch_direct_store_i
                     | fetch_prot_i);
   // Alignment; plain misalignment under swapped order is deliberately absent
   assign al_req   = al_valid_i & (
                        (al_fp_i & (al_misalign_i | al_direct_store_i))
                      | (al_word_op_i & al_misalign_i)
                      | (al_seg_cross_i & al_ds_change_i)
                      | (al_zero_blk_i & al_wt_or_ci_i)
                      | (al_multi_str_i & cfg_ff[CFG_SWAP])
                      | (al_ext_ctl_i & al_misalign_i));
   // Maskable async only at an instruction boundary or with units empty
   assign async_ok = exec_empty_i | instr_done_i;
   assign ext_req  = cfg_ff[CFG_EXT_EN] & irq_ctrl_int_i;
   assign dcnt_req = cfg_ff[CFG_EXT_EN] & dcnt_pend_ff;
   assign mgmt_req = cfg_ff[CFG_EXT_EN] & sys_mgmt_irq_i;

   // ***************************************************
   // Priority select
   // ***************************************************
   // Reset and check preempt even a running handler
   always_comb begin
      nxt_take    = 1'b1;
      nxt_vector  = VEC_NONE;
      nxt_sync    = 1'b0;
      nxt_precise = 1'b1;
      if (rst_req) begin
         nxt_vector  = VEC_RESET;
         nxt_precise = 1'b0;
      end else if (mchk_req) begin
         nxt_vector  = VEC_MCHK;
         nxt_precise = 1'b0;
      end else if (idle && fetch_req) begin
         nxt_vector  = VEC_FETCH;
         nxt_sync    = 1'b1;
      end else if (idle && dsi_req) begin
         nxt_vector  = VEC_DSI;
         nxt_sync    = 1'b1;
      end else if (idle && al_req) begin
         nxt_vector  = VEC_ALIGN;
         nxt_sync    = 1'b1;
      end else if (idle && async_ok && ext_req) begin
         nxt_vector  = VEC_EXT;
      end else if (idle && async_ok && dcnt_req) begin
         nxt_vector  = VEC_DCNT;
      end else if (idle && async_ok && mgmt_req) begin
         nxt_vector  = VEC_MGMT;
      end else begin
         nxt_take    = 1'b0;
      end
   end

   // ***************************************************
   // Dispatch outputs and handler state
   // ***************************************************
   // Registered dispatch; take is high one cycle after each enabled cycle in which a request is selected
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         take_ff    <= 1'b0;
         vector_ff  <= VEC_NONE;
         sync_ff    <= 1'b0;
         precise_ff <= 1'b1;
      end else if (clk_en_i) begin
         take_ff <= nxt_take;
         if (nxt_take) begin
            vector_ff  <= nxt_vector;
            sync_ff    <= nxt_sync;
            precise_ff <= nxt_precise;
         end
      end
   end

   // Busy from take until handler return; a new take keeps it busy
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_ff <= ST_IDLE;
      end else if (clk_en_i) begin
         unique case (state_ff)
            ST_IDLE:   if (nxt_take) state_ff <= ST_HANDLE;
            ST_HANDLE: if (handler_done_i && !nxt_take) state_ff <= ST_IDLE;
         endcase
      end
   end

   // Check output held through the handler; set wins over clear
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         mout_ff <= 1'b0;
      end else if (clk_en_i) begin
         if (nxt_take && nxt_vector == VEC_MCHK)
            mout_ff <= 1'b1;
         else if (handler_done_i)
            mout_ff <= 1'b0;
      end
   end

   // Rising top bit stays pending until taken; a new edge wins
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         dcnt_prev_ff <= 1'b0;
         dcnt_pend_ff <= 1'b0;
      end else if (clk_en_i) begin
         dcnt_prev_ff <= down_counter_msb_i;
         if (down_counter_msb_i && !dcnt_prev_ff)
            dcnt_pend_ff <= 1'b1;
         else if (nxt_take && nxt_vector == VEC_DCNT)
            dcnt_pend_ff <= 1'b0;
      end
   end

   // ***************************************************
   // Cause registers, loaded only with the fault taken
   // ***************************************************
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         dcause_ff <= '0;
      end else if (clk_en_i && nxt_take && nxt_vector == VEC_DSI) begin
         dcause_ff[DC_NOXL]   <= dacc_no_xlate_i;
         dcause_ff[DC_PROT]   <= dacc_prot_i;
         dcause_ff[DC_WT_DS]  <= (dacc_ext_ctl_i & dacc_write_thru_i)
                                 | dacc_direct_store_i;
         dcause_ff[DC_STORE]  <= dacc_store_i;
         dcause_ff[DC_EARDIS] <= dacc_ext_ctl_i & ~cfg_ff[CFG_XACC_EN];
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         saved_ff <= '0;
      end else if (clk_en_i && nxt_take && nxt_vector == VEC_FETCH) begin
         saved_ff          <= '0;
         saved_ff[SR_NOXL] <= fetch_no_xlate_i;
         saved_ff[SR_DS]   <= fetch_direct_store_i;
         saved_ff[SR_PROT] <= fetch_prot_i;
      end
   end

   // ***************************************************
   // APB slave, one wait state
   // ***************************************************
   assign apb_setup = psel_i & ~penable_i;
   assign apb_wr    = psel_i & penable_i & pready_ff & pwrite_i;
   assign hit = (paddr_i == OFF_CFG) | (paddr_i == OFF_STAT)
              | (paddr_i == OFF_DCAUSE) | (paddr_i == OFF_SAVED);

   always_comb begin
      rd_mux = '0;
      unique case (paddr_i)
         OFF_CFG:    rd_mux = cfg_ff;
         OFF_STAT:   begin
            rd_mux[VW-1:0]    = vector_ff;
            rd_mux[STAT_MOUT] = mout_ff;
            rd_mux[STAT_BUSY] = ~idle;
         end
         OFF_DCAUSE: rd_mux[DC_W-1:0] = dcause_ff;
         OFF_SAVED:  rd_mux[SR_W-1:0] = saved_ff;
         default:    rd_mux = '0;
      endcase
   end

   // Ready rises in the second access cycle, data sampled then
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         pready_ff  <= 1'b0;
         pslverr_ff <= 1'b0;
         prdata_ff  <= '0;
      end else if (clk_en_i) begin
         pready_ff  <= psel_i & penable_i & ~pready_ff;
         pslverr_ff <= psel_i & penable_i & ~pready_ff & ~hit;
         if (psel_i && penable_i && !pready_ff && !pwrite_i)
            prdata_ff <= rd_mux;
         else if (apb_setup)
            prdata_ff <= '0;
      end
   end

   // Only the config word is writable
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         cfg_ff <= CFG_RST;
      end else if (clk_en_i && apb_wr && paddr_i == OFF_CFG) begin
         cfg_ff <= pwdata_i;
      end
   end

   assign prdata_o            = prdata_ff;
   assign pready_o            = pready_ff;
   assign pslverr_o           = pslverr_ff;
   assign take_o              = take_ff;
   assign vector_o            = vector_ff;
   assign sync_o              = sync_ff;
   assign precise_o           = precise_ff;
   assign busy_o              = (state_ff == ST_HANDLE);
   assign machine_check_out_o = mout_ff;

   // ***************************************************
   // Assertions
   // ***************************************************
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);

   reset_vector_a: assert property (clk_en_i && rst_req |=> take_o && vector_o == VEC_RESET)
      else $error("reset request not vectored to reset");
   nonmask_class_a: assert property (take_o && (vector_o == VEC_RESET
      || vector_o == VEC_MCHK) |-> !precise_o && !sync_o)
      else $error("nonmaskable exception reported precise");
   sync_precise_a: assert property (take_o && sync_o |-> precise_o)
      else $error("synchronous exception reported imprecise");
   mchk_gate_a: assert property (take_o && vector_o == VEC_MCHK |->
      $past(cfg_ff[CFG_MCHK_EN]) && $past(cfg_ff[CFG_PIN_EN])
      && $past(cfg_ff[CFG_MOUT_EN]))
      else $error("machine check taken while disabled");
   mchk_out_a: assert property (take_o && vector_o == VEC_MCHK |-> machine_check_out_o)
      else $error("machine check output not raised");
   ext_gate_a: assert property (take_o && vector_o == VEC_EXT |->
      $past(cfg_ff[CFG_EXT_EN]) && $past(irq_ctrl_int_i) && $past(async_ok))
      else $error("external interrupt taken while masked");
   dsi_dir_a: assert property (clk_en_i && nxt_take && nxt_vector == VEC_DSI
      |=> dcause_ff[DC_STORE] == $past(dacc_store_i))
      else $error("data fault direction not recorded");
   fetch_ds_a: assert property (clk_en_i && nxt_take && nxt_vector == VEC_FETCH
      && fetch_direct_store_i |=> saved_ff[SR_DS] && vector_o == VEC_FETCH)
      else $error("direct-store fetch not flagged");
   le_misalign_a: assert property (clk_en_i && idle && !rst_req && !mchk_req
      && !fetch_req && !dsi_req && al_valid_i && al_misalign_i && cfg_ff[CFG_SWAP]
      && !al_fp_i && !al_word_op_i && !al_ext_ctl_i && !al_multi_str_i
      && !al_seg_cross_i && !al_zero_blk_i |=> vector_o != VEC_ALIGN || !take_o)
      else $error("alignment raised for byte-swapped misalignment");
   dcnt_edge_a: assert property (clk_en_i && down_counter_msb_i && !dcnt_prev_ff
      |=> dcnt_pend_ff)
      else $error("decrementer edge lost");
   one_at_time_a: assert property (take_o && busy_o && $past(busy_o) |->
      vector_o == VEC_RESET || vector_o == VEC_MCHK)
      else $error("maskable exception dispatched while busy");

   reset_take_c: cover property (take_o && vector_o == VEC_RESET);
   mchk_take_c:  cover property (take_o && vector_o == VEC_MCHK);
   dsi_take_c:   cover property (take_o && vector_o == VEC_DSI);
   dcnt_take_c:  cover property (take_o && vector_o == VEC_DCNT);
endmodule

// *** core/cxd_pkg.sv ***
// Purpose: Constants for the core exception dispatch block.
// Assumes: 32-bit APB, byte addresses, one word per register.
// Notes:   Vector offsets are 20-bit physical offsets.
package cxd_pkg;
   localparam int DW = 32;
   localparam int AW = 8;
   localparam int VW = 20;
   // ***************************************************
   // Vector offsets
   // ***************************************************
   localparam logic [VW-1:0] VEC_NONE  = 20'h00000;
   localparam logic [VW-1:0] VEC_RESET = 20'h00100;
   localparam logic [VW-1:0] VEC_MCHK  = 20'h00200;
   localparam logic [VW-1:0] VEC_DSI   = 20'h00300;
   localparam logic [VW-1:0] VEC_FETCH = 20'h00400;
   localparam logic [VW-1:0] VEC_EXT   = 20'h00500;
   localparam logic [VW-1:0] VEC_ALIGN = 20'h00600;
   localparam logic [VW-1:0] VEC_DCNT  = 20'h00900;
   // ***************************************************
   // Register map and fields
   // ***************************************************
   localparam logic [AW-1:0] OFF_CFG    = 8'h00;
   localparam logic [AW-1:0] OFF_STAT   = 8'h04;
   localparam logic [AW-1:0] OFF_DCAUSE = 8'h08;
   localparam logic [AW-1:0] OFF_SAVED  = 8'h0c;
   localparam logic [DW-1:0] CFG_RST    = 32'h0000_0000;
   localparam int CFG_PIN_EN  = 0;
   localparam int CFG_MOUT_EN = 1;
   localparam int CFG_MCHK_EN = 2;
   localparam int CFG_EXT_EN  = 3;
   localparam int CFG_SWAP    = 4;
   localparam int CFG_XACC_EN = 5;
   localparam int CFG_ERR_LSB = 8;
   localparam int STAT_BUSY   = 31;
   localparam int STAT_MOUT   = 30;
   localparam int DC_NOXL     = 0;
   localparam int DC_PROT     = 1;
   localparam int DC_WT_DS    = 2;
   localparam int DC_STORE    = 3;
   localparam int DC_EARDIS   = 4;
   localparam int DC_W        = 5;
   localparam int SR_NOXL     = 1;
   localparam int SR_DS       = 3;
   localparam int SR_PROT     = 4;
   localparam int SR_W        = 5;
   typedef enum logic [0:0] {
      ST_IDLE   = 1'b0,
      ST_HANDLE = 1'b1
   } cxd_state_t;
endpackage

// *** test/cxd_core_model.sv ***
// Purpose: Core pipeline stand-in on the far side of the dispatch block.
// Assumes: One clock, synchronous active-high reset.
// Notes:   Units never report empty, so maskable requests wait for a boundary.
module cxd_core_model (
   input  wire logic ref_clk_i,
   input  wire logic rst_i,
   input  wire logic busy_i,
   output logic      instr_done_o,
   output logic      exec_empty_o,
   output logic      handler_done_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [2:0] cnt_ff;
   logic [1:0] hcnt_ff;
   // Boundary every fourth cycle, so a request cannot ride on a lucky edge
   always_ff @(posedge ref_clk_i) begin
      cnt_ff       <= rst_i ? 3'h0 : cnt_ff + 3'h1;
      instr_done_o <= !rst_i && (cnt_ff[1:0] == 2'h3);
   end
   // Handler returns three cycles into busy; a pulse, never a level
   always_ff @(posedge ref_clk_i) begin
      hcnt_ff        <= (rst_i || !busy_i || handler_done_o) ? 2'h0 : hcnt_ff + 2'h1;
      handler_done_o <= !rst_i && busy_i && (hcnt_ff == 2'h2) && !handler_done_o;
   end
   assign exec_empty_o = 1'b0; // Empty path left to the boundary path
endmodule

// *** test/testbench.sv ***
// Purpose: Self-checking bench for the exception dispatch block.
// Assumes: Default NERR and VEC_MGMT; one APB word per access.
// Notes:   Handler return comes from the core model.
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   import cxd_pkg::*;
   logic          ref_clk_i = 1'b0;
   logic          rst_i = 1'b1;
   logic          clk_en_i = 1'b1;
   logic          psel_i, penable_i, pwrite_i, pready_o, pslverr_o, er;
   logic          hard_core_reset_i, soft_reset_pin_i, irq_ctrl_sreset_i, nmi_i;
   logic          irq_ctrl_int_i, sys_mgmt_irq_i, down_counter_msb_i;
   logic          instr_done_i, exec_empty_i, handler_done_i;
   logic          dacc_valid_i, dacc_no_xlate_i, dacc_prot_i, dacc_ext_ctl_i;
   logic          dacc_write_thru_i, dacc_direct_store_i, dacc_store_i;
   logic          fetch_valid_i, fetch_no_xlate_i, fetch_direct_store_i, fetch_prot_i;
   logic          al_valid_i, al_fp_i, al_word_op_i, al_misalign_i, al_direct_store_i;
   logic          al_seg_cross_i, al_ds_change_i, al_zero_blk_i, al_wt_or_ci_i;
   logic          al_multi_str_i, al_ext_ctl_i;
   logic          take_o, sync_o, precise_o, busy_o, machine_check_out_o;
   logic [AW-1:0] paddr_i;
   logic [DW-1:0] pwdata_i, prdata_o, rd;
   logic [7:0]    int_err_i;
   logic [VW-1:0] vector_o;
   int            failures = 0;
   int            num_checks = 0;
   int            takes = 0;
   `define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin failures++; \
      $display("ERROR %0t value mismatch", $time); end end
   `define RSTS {hard_core_reset_i, soft_reset_pin_i, irq_ctrl_sreset_i}
   `define MASK {sys_mgmt_irq_i, down_counter_msb_i, irq_ctrl_int_i}
   `define DACC {dacc_valid_i, dacc_no_xlate_i, dacc_prot_i, dacc_ext_ctl_i, \
      dacc_write_thru_i, dacc_direct_store_i, dacc_store_i}
   `define FET {fetch_valid_i, fetch_no_xlate_i, fetch_direct_store_i, fetch_prot_i}
   `define AL {al_valid_i, al_fp_i, al_word_op_i, al_misalign_i, al_direct_store_i, \
      al_seg_cross_i, al_ds_change_i, al_zero_blk_i, al_wt_or_ci_i, al_multi_str_i, al_ext_ctl_i}
   cxd_exception_dispatch i_cxd_exception_dispatch (.*);
   cxd_core_model i_cxd_core_model (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .busy_i(busy_o),
      .instr_done_o(instr_done_i), .exec_empty_o(exec_empty_i),
      .handler_done_o(handler_done_i));
   // Free-running clock and a tally of dispatches
   always #25 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) if (take_o === 1'b1) takes++;
   task test_done;
      $display("checks %0d failures %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task tmo;
      failures++;
      $display("ERROR %0t wait ran out", $time);
      test_done();
   endtask
   // One APB transfer; held until pready is seen at an edge
   task apb(input logic w, input logic [AW-1:0] a, input logic [DW-1:0] d);
      int n;
      n = 0;
      @(posedge ref_clk_i) {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'h2, w, a, d};
      @(posedge ref_clk_i) penable_i <= 1'b1;
      do begin @(posedge ref_clk_i); n++; end while (pready_o !== 1'b1 && n < 20);
      if (n >= 20) tmo();
      rd = prdata_o;
      er = pslverr_o;
      {psel_i, penable_i} <= 2'h0;
   endtask
   // Wait for a dispatch and judge its vector and class
   task wt(input logic [VW-1:0] v, input logic s, input logic p, input logic m);
      int n;
      n = 0;
      #1;
      while (take_o !== 1'b1 && n < 40) begin @(posedge ref_clk_i); #1; n++; end
      if (n >= 40) tmo();
      `CHK(vector_o, v)
      `CHK(sync_o, s)
      `CHK(precise_o, p)
      `CHK(machine_check_out_o, m)
      `CHK(busy_o, 1'b1)
   endtask
   task idle;
      int n;
      n = 0;
      while (busy_o !== 1'b0 && n < 40) begin @(posedge ref_clk_i); n++; end
      if (n >= 40) tmo();
   endtask
   task quiet;
      int t;
      t = takes;
      repeat (8) @(posedge ref_clk_i);
      `CHK(takes, t)
   endtask
   task mck(input logic [8:0] s, input logic e);
      @(posedge ref_clk_i) {nmi_i, int_err_i} <= s;
      @(posedge ref_clk_i) {nmi_i, int_err_i} <= 9'h000;
      if (e) begin wt(VEC_MCHK, 1'b0, 1'b0, 1'b1); idle(); end else quiet();
   endtask
   task dsi(input logic [5:0] b, input logic [4:0] c);
      @(posedge ref_clk_i) `DACC <= {1'b1, b};
      @(posedge ref_clk_i) `DACC <= 7'h00;
      wt(VEC_DSI, 1'b1, 1'b1, 1'b0);
      idle();
      apb(1'b0, OFF_DCAUSE, 32'h0);
      `CHK(rd, {27'h0, c})
   endtask
   task fetch_flt(input logic [2:0] b, input logic [DW-1:0] c);
      @(posedge ref_clk_i) `FET <= {1'b1, b};
      @(posedge ref_clk_i) `FET <= 4'h0;
      wt(VEC_FETCH, 1'b1, 1'b1, 1'b0);
      idle();
      apb(1'b0, OFF_SAVED, 32'h0);
      `CHK(rd, c)
   endtask
   task al(input logic [9:0] b, input logic e);
      @(posedge ref_clk_i) `AL <= {1'b1, b};
      @(posedge ref_clk_i) `AL <= 11'h000;
      if (e) begin wt(VEC_ALIGN, 1'b1, 1'b1, 1'b0); idle(); end else quiet();
   endtask
   task msk(input int k, input logic [VW-1:0] v);
      @(posedge ref_clk_i) `MASK <= 3'h1 << k;
      wt(v, 1'b0, 1'b1, 1'b0);
      @(posedge ref_clk_i) `MASK <= 3'h0;
      idle();
   endtask
   // Main sequence: reset, registers, then each exception class
   initial begin
      {psel_i, penable_i, pwrite_i, paddr_i, pwdata_i, int_err_i, nmi_i} = '0;
      {`RSTS, `MASK, `DACC, `FET, `AL} = '0;
      repeat (6) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      #1;
      `CHK({take_o, busy_o, precise_o, vector_o}, {3'h1, VEC_NONE})
      apb(1'b0, OFF_CFG, 32'h0);
      `CHK(rd, CFG_RST)
      apb(1'b0, 8'h10, 32'h0);
      `CHK({er, rd}, {1'b1, 32'h0})
      for (int k = 0; k < 3; k++) begin
         @(posedge ref_clk_i) `RSTS <= 3'h1 << k;
         @(posedge ref_clk_i) `RSTS <= 3'h0;
         wt(VEC_RESET, 1'b0, 1'b0, 1'b0);
         idle();
      end
      mck(9'h100, 1'b0);
      apb(1'b1, OFF_CFG, 32'h0000_f707);
      mck(9'h008, 1'b0);
      mck(9'h100, 1'b1);
      apb(1'b1, OFF_CFG, 32'h0000_ff07);
      mck(9'h008, 1'b1);
      apb(1'b1, OFF_CFG, 32'h0000_ff05);
      mck(9'h100, 1'b0);
      apb(1'b1, OFF_CFG, 32'h0000_ff03);
      mck(9'h100, 1'b0);
      dsi(6'h21, 5'h09);
      dsi(6'h10, 5'h02);
      dsi(6'h0c, 5'h14);
      dsi(6'h02, 5'h04);
      apb(1'b1, OFF_CFG, 32'h0000_0020);
      dsi(6'h0c, 5'h04);
      fetch_flt(3'h4, 32'h2);
      fetch_flt(3'h2, 32'h8);
      fetch_flt(3'h1, 32'h10);
      al(10'h280, 1'b1);
      al(10'h240, 1'b1);
      al(10'h180, 1'b1);
      al(10'h030, 1'b1);
      al(10'h020, 1'b0);
      al(10'h00c, 1'b1);
      al(10'h081, 1'b1);
      al(10'h002, 1'b0);
      apb(1'b1, OFF_CFG, 32'h0000_0010);
      al(10'h002, 1'b1);
      al(10'h080, 1'b0);
      @(posedge ref_clk_i) irq_ctrl_int_i <= 1'b1;
      quiet();
      apb(1'b1, OFF_CFG, 32'h0000_0008);
      irq_ctrl_int_i <= 1'b0;
      msk(0, VEC_EXT);
      msk(1, VEC_DCNT);
      msk(2, 20'h00f00);
      @(posedge ref_clk_i) {`FET, `DACC} <= {4'hc, 7'h60};
      @(posedge ref_clk_i) {`FET, `DACC} <= '0;
      wt(VEC_FETCH, 1'b1, 1'b1, 1'b0);
      idle();
      apb(1'b1, OFF_CFG, 32'h0000_ff07);
      @(posedge ref_clk_i) {hard_core_reset_i, nmi_i} <= 2'h3;
      @(posedge ref_clk_i) {hard_core_reset_i, nmi_i} <= 2'h0;
      wt(VEC_RESET, 1'b0, 1'b0, 1'b0);
      idle();
      test_done();
   end
endmodule
